//--- digit_entry_consts.svh
// Constants for the serial digit entry and flag output block.
// Assumes inclusion by bare name from the package and design modules.
`ifndef DIGIT_ENTRY_CONSTS_SVH
`define DIGIT_ENTRY_CONSTS_SVH
// Largest digit code that is a decimal numeral.
`define DIGIT_MAX_NUMERAL 4'h9
// Entry instruction codes above the numeral range.
`define CODE_POINT 4'ha
`define CODE_NEGATE 4'hb
`define CODE_NEGATE_NOP 4'ha
`define CODE_EXPONENT 4'hc
`define CODE_RESUME 4'hf
// Width of one digit code.
`define DIGIT_W 4
// Depth of the digit FIFO.
`define FIFO_DEPTH 4
// Number of flag outputs.
`define FLAG_COUNT 4
// Flag output reset value, all inactive high.
`define FLAG_IDLE 4'hf
`endif

//--- digit_entry_pkg.sv
// Types shared by the digit entry block.
// Assumes the constants header is on the include path.
`include "digit_entry_consts.svh"
package digit_entry_pkg;
   // Kind of a digit code after classification.
   typedef enum logic [2:0] {
      KIND_NUMERAL = 3'h0,
      KIND_POINT = 3'h1,
      KIND_NEGATE = 3'h2,
      KIND_EXPONENT = 3'h3,
      KIND_RESUME = 3'h4,
      KIND_OTHER = 3'h5
   } code_kind_t;
   // Request state of the serial link.
   typedef enum logic [1:0] {
      REQ_IDLE = 2'h0,
      REQ_WAIT = 2'h1,
      REQ_DONE = 2'h2
   } req_state_t;
endpackage : digit_entry_pkg

//--- digit_fifo.sv
// Small flip-flop FIFO carrying digit codes with valid/ready on both sides.
// Assumes both sides share clk_sys and srst.
`timescale 1ns/1ps
module digit_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 4
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("digit_fifo depth must be a power of two of at least two");
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Storage and pointers; pointers carry one extra bit to tell full from empty.
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;
   assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // Write pointer and storage advance on each accepted word.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr <= '0;
      end else if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
         wr_ptr <= wr_ptr + 1'b1;
      end
   end
   // Read pointer advances on each drained word.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : digit_fifo

//--- digit_entry.sv
// Serial digit entry with instruction decode and four flag outputs.
// Assumes the peripheral drives digit data and a digit clock on its own link clock,
// and the calculator core consumes classified codes and sets software flags.
`timescale 1ns/1ps
`include "digit_entry_consts.svh"
module digit_entry
   import digit_entry_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH
) (
   // System clock and reset.
   input wire logic clk_sys,
   input wire logic srst,
   // Link clock from the peripheral.
   input wire logic link_clk,
   // Serial digit link; inputs sampled on link_clk, request driven on clk_sys.
   input wire logic [3:0] digit_data,
   input wire logic digit_clock,
   input wire logic end_of_data,
   output logic digit_request_n,
   // Core side: start entry of a digit string and receive classified codes.
   input wire logic entry_start,
   output logic code_valid,
   input wire logic code_ready,
   output logic [3:0] code_value,
   output logic [2:0] code_kind,
   output logic numeral_valid,
   // Software flags and flag instruction strobe.
   input wire logic [3:0] soft_flags,
   input wire logic flag_instr,
   input wire logic inhibit,
   output logic [3:0] flag_out_n,
   output logic transfer_flag_output
);
   initial begin
      if (DEPTH < 2) begin
         $error("digit_entry needs a FIFO depth of at least two");
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // System domain: request handshake toward the link.
   req_state_t state;
   logic req_toggle; // Flips once per digit request.
   logic ack_s1; // First stage of acknowledge synchroniser.
   logic ack_s2; // Second stage.
   logic ack_s3; // Delayed copy for edge detection.
   logic [4:0] cap_word; // Captured digit plus end flag, crossed as a held word.
   logic entering; // High while a serial string is being taken.
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [4:0] fifo_out_data;
   logic ack_event;
   logic link_ack; // Toggles in the link domain when a digit is loaded.
   logic [4:0] link_word; // Loaded digit and end of data flag, held until the next load.
   assign ack_event = ack_s2 ^ ack_s3;
   // Request state machine: one outstanding request at a time.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= REQ_IDLE;
         req_toggle <= 1'b0;
      end else begin
         unique case (state)
            REQ_IDLE: begin
               // Request only while the FIFO can hold the answer.
               if (entering && fifo_in_ready) begin
                  req_toggle <= ~req_toggle;
                  state <= REQ_WAIT;
               end
            end
            REQ_WAIT: begin
               // Answer arrived from the link.
               if (ack_event) begin
                  state <= REQ_DONE;
               end
            end
            REQ_DONE: begin
               state <= REQ_IDLE;
            end
            default: begin
               state <= REQ_IDLE;
            end
         endcase
      end
   end
   // Entry runs from start until the end of data word is queued.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         entering <= 1'b0;
      end else if (state == REQ_DONE && cap_word[4]) begin
         entering <= 1'b0;
      end else if (entry_start) begin
         entering <= 1'b1;
      end
   end
   // Active low request held from issue until the digit clock is seen.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         digit_request_n <= 1'b1;
      end else begin
         digit_request_n <= !(state == REQ_WAIT && !ack_event);
      end
   end
   // Acknowledge toggle synchroniser into the system domain.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
      end else begin
         ack_s1 <= link_ack;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
      end
   end
   // Captured word is stable by the time the acknowledge has crossed.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cap_word <= 5'h00;
      end else if (ack_event) begin
         cap_word <= link_word;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Link domain: take one digit per digit clock pulse.
   logic dclk_s1; // Digit clock synchroniser, first stage.
   logic dclk_s2;
   logic dclk_s3;
   logic [3:0] data_s1; // Data synchroniser.
   logic [3:0] data_s2;
   logic eod_s1;
   logic eod_s2;
   logic link_rst_s1; // Reset synchroniser into the link domain, first stage.
   logic link_rst; // Second stage, the reset seen by the link domain.
   // Pins pass two flip-flops before use.
   always_ff @(posedge link_clk) begin
      dclk_s1 <= digit_clock;
      dclk_s2 <= dclk_s1;
      dclk_s3 <= dclk_s2;
      data_s1 <= digit_data;
      data_s2 <= data_s1;
      eod_s1 <= end_of_data;
      eod_s2 <= eod_s1;
   end
   // System reset crosses into the link domain through two flip-flops.
   always_ff @(posedge link_clk) begin
      link_rst_s1 <= srst;
      link_rst <= link_rst_s1;
   end
   // Rising edge of the digit clock loads the word; end of data picks resume.
   // The reset keeps the acknowledge toggle in step with the system side.
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         link_word <= 5'h00;
         link_ack <= 1'b0;
      end else if (dclk_s2 && !dclk_s3) begin
         link_word <= eod_s2 ? {1'b1, `CODE_RESUME} : {1'b0, data_s2};
         link_ack <= ~link_ack;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // FIFO between the link answers and the core.
   digit_fifo #(
      .WIDTH(5),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(state == REQ_DONE),
      .in_ready(fifo_in_ready),
      .in_data(cap_word),
      .out_valid(fifo_out_valid),
      .out_ready(!code_valid || code_ready),
      .out_data(fifo_out_data)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Output register: classify each code.
   code_kind_t kind;
   always_comb begin
      if (fifo_out_data[3:0] <= `DIGIT_MAX_NUMERAL) begin
         kind = KIND_NUMERAL;
      end else if (fifo_out_data[3:0] == `CODE_POINT) begin
         kind = KIND_POINT;
      end else if (fifo_out_data[3:0] == `CODE_NEGATE) begin
         kind = KIND_NEGATE;
      end else if (fifo_out_data[3:0] == `CODE_EXPONENT) begin
         kind = KIND_EXPONENT;
      end else if (fifo_out_data[3:0] == `CODE_RESUME) begin
         kind = KIND_RESUME;
      end else begin
         kind = KIND_OTHER;
      end
   end
   // Holds a code until the core takes it.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         code_valid <= 1'b0;
         code_value <= 4'h0;
         code_kind <= 3'h0;
         numeral_valid <= 1'b0;
      end else if (!code_valid || code_ready) begin
         code_valid <= fifo_out_valid;
         code_value <= fifo_out_data[3:0];
         code_kind <= kind;
         numeral_valid <= fifo_out_valid && kind == KIND_NUMERAL;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Flag outputs, active low, four of them.
   logic entry_taken;
   assign entry_taken = code_valid && code_ready;
   // Inhibit forces all high; instructions and entries copy the soft flags.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flag_out_n <= `FLAG_IDLE;
         transfer_flag_output <= 1'b1;
      end else if (inhibit) begin
         flag_out_n <= `FLAG_IDLE;
         transfer_flag_output <= 1'b1;
      end else if (flag_instr || entry_taken) begin
         flag_out_n <= ~soft_flags;
         transfer_flag_output <= ~soft_flags[3];
      end
   end
endmodule : digit_entry

//--- digit_entry_properties.sv
// Port checker for the digit entry block.
// Assumes a bind onto digit_entry; all checks run on clk_sys.
`timescale 1ns/1ps
module digit_entry_properties
   import digit_entry_pkg::*;
#(
   parameter int DEPTH = 4
) (
   // Clocks and reset.
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic link_clk,
   // Serial link.
   input wire logic [3:0] digit_data,
   input wire logic digit_clock,
   input wire logic end_of_data,
   input wire logic digit_request_n,
   // Core side.
   input wire logic entry_start,
   input wire logic code_valid,
   input wire logic code_ready,
   input wire logic [3:0] code_value,
   input wire logic [2:0] code_kind,
   input wire logic numeral_valid,
   // Flags.
   input wire logic [3:0] soft_flags,
   input wire logic flag_instr,
   input wire logic inhibit,
   input wire logic [3:0] flag_out_n,
   input wire logic transfer_flag_output
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic seen; // High once a digit clock came during the open request.
   // Remembers a digit clock until the request is withdrawn.
   always_ff @(posedge clk_sys) begin
      if (srst || digit_request_n) begin
         seen <= 1'b0;
      end else if (digit_clock) begin
         seen <= 1'b1;
      end
   end
   // A code is handed over, or a flag instruction arrives while enabled.
   sequence cause_s;
      (flag_instr || (code_valid && code_ready)) && !inhibit;
   endsequence
   a_reset_idle: assert property ($fell(srst) |->
      digit_request_n && !code_valid && flag_out_n == 4'hf) else $error("outputs busy at reset");
   a_flag_copy: assert property (cause_s |=>
      flag_out_n == ~$past(soft_flags)) else $error("flags not copied");
   a_inhibit_high: assert property (inhibit |=> flag_out_n == 4'hf)
      else $error("flags active while inhibited");
   a_flag_hold: assert property (!flag_instr && !(code_valid && code_ready) && !inhibit
      |=> $stable(flag_out_n)) else $error("flags moved without cause");
   a_transfer_copy: assert property (transfer_flag_output == flag_out_n[3])
      else $error("transfer flag differs");
   a_code_hold: assert property (code_valid && !code_ready |=>
      code_valid && $stable(code_value) && $stable(code_kind)) else $error("code dropped");
   a_numeral_flag: assert property (code_valid |->
      numeral_valid == (code_value <= 4'h9)) else $error("numeral flag wrong");
   a_kind_numeral: assert property (code_valid |->
      (code_kind == KIND_NUMERAL) == (code_value <= 4'h9)) else $error("kind wrong");
   a_request_waits: assert property (!digit_request_n && !seen && !digit_clock
      |=> !digit_request_n) else $error("request withdrawn early");
endmodule : digit_entry_properties
bind digit_entry digit_entry_properties #(.DEPTH(DEPTH)) u_props (.clk_sys(clk_sys),
   .srst(srst), .link_clk(link_clk), .digit_data(digit_data), .digit_clock(digit_clock),
   .end_of_data(end_of_data), .digit_request_n(digit_request_n), .entry_start(entry_start),
   .code_valid(code_valid), .code_ready(code_ready), .code_value(code_value),
   .code_kind(code_kind), .numeral_valid(numeral_valid), .soft_flags(soft_flags),
   .flag_instr(flag_instr), .inhibit(inhibit), .flag_out_n(flag_out_n),
   .transfer_flag_output(transfer_flag_output));

//--- peripheral_model.sv
// Peripheral that answers each digit request on one digit position.
// Assumes the bench queues the digit string through put before starting entry.
`timescale 1ns/1ps
module peripheral_model (
   output logic link_clk,
   input wire logic digit_request_n,
   output logic [3:0] digit_data,
   output logic digit_clock,
   output logic end_of_data
);
   logic [3:0] q[$]; // Digits still to send, already in decimal code.
   task automatic put(input logic [3:0] d);
      q.push_back(d);
   endtask : put
   // Link clock with a phase unrelated to the system clock.
   initial begin
      link_clk = 1'b0;
      #17;
      forever #62.5 link_clk = ~link_clk;
   end
   // Each request gets data, then a pulse; an empty queue ends the string.
   initial begin
      digit_data = 4'h0;
      digit_clock = 1'b0;
      end_of_data = 1'b0;
      forever begin
         @(posedge link_clk);
         if (digit_request_n === 1'b0) begin
            if (q.size() > 0) digit_data <= q.pop_front();
            else end_of_data <= 1'b1;
            @(posedge link_clk) digit_clock <= 1'b1;
            repeat (2) @(posedge link_clk);
            digit_clock <= 1'b0;
            end_of_data <= 1'b0;
            digit_data <= ~digit_data; // Hold time over, the line no longer holds.
            while (digit_request_n !== 1'b1) @(posedge link_clk);
         end
      end
   end
endmodule : peripheral_model

//--- digit_entry_bench.sv
// Self-checking bench for the digit entry block.
// Assumes the model and the checker are compiled before it.
`timescale 1ns/1ps
module digit_entry_bench;
   import digit_entry_pkg::*;
   logic clk_sys, srst, link_clk, digit_clock, end_of_data, digit_request_n, entry_start;
   logic code_valid, code_ready, numeral_valid, flag_instr, inhibit, transfer_flag_output;
   logic [3:0] digit_data, code_value, soft_flags, flag_out_n;
   logic [2:0] code_kind;
   int error_cnt, checks;
   digit_entry #(.DEPTH(4)) uut (.clk_sys(clk_sys), .srst(srst), .link_clk(link_clk),
      .digit_data(digit_data), .digit_clock(digit_clock), .end_of_data(end_of_data),
      .digit_request_n(digit_request_n), .entry_start(entry_start), .code_valid(code_valid),
      .code_ready(code_ready), .code_value(code_value), .code_kind(code_kind),
      .numeral_valid(numeral_valid), .soft_flags(soft_flags), .flag_instr(flag_instr),
      .inhibit(inhibit), .flag_out_n(flag_out_n), .transfer_flag_output(transfer_flag_output));
   peripheral_model per (.link_clk(link_clk), .digit_request_n(digit_request_n),
      .digit_data(digit_data), .digit_clock(digit_clock), .end_of_data(end_of_data));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic strobe(ref logic s);
      s = 1'b1;
      @(negedge clk_sys) s = 1'b0;
      @(negedge clk_sys);
   endtask : strobe
   // Waits for a code, compares it, then takes it in one cycle.
   task automatic take(input logic [3:0] v, input logic [2:0] k);
      int n;
      n = 0;
      while (code_valid !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      if (code_valid !== 1'b1) begin
         error_cnt++;
         $display("[ERR] %0t code wait timed out got %h exp %h", $time, code_valid, 1'b1);
      end
      chk(code_value, v);
      chk(code_kind, k);
      chk(numeral_valid, v <= 4'h9);
      code_ready = 1'b1;
      @(negedge clk_sys) code_ready = 1'b0;
      @(negedge clk_sys);
   endtask : take
   task automatic t_reset;
      chk({digit_request_n, code_valid, transfer_flag_output}, 4'h5);
      chk(flag_out_n, 4'hf);
   endtask : t_reset
   // Scientific entry 1.9 E 0, negated, plus an unused code.
   task automatic t_string;
      logic [3:0] dv [7] = '{4'h1, 4'ha, 4'h9, 4'hc, 4'h0, 4'hb, 4'hd};
      logic [2:0] dk [7] = '{KIND_NUMERAL, KIND_POINT, KIND_NUMERAL, KIND_EXPONENT,
         KIND_NUMERAL, KIND_NEGATE, KIND_OTHER};
      foreach (dv[i]) per.put(dv[i]);
      strobe(entry_start);
      foreach (dv[i]) take(dv[i], dk[i]);
      take(4'hf, KIND_RESUME);
   endtask : t_string
   // Core stalls until the buffer refuses, then drains it.
   task automatic t_stall;
      for (int i = 0; i < 6; i++) per.put(4'(i + 2));
      strobe(entry_start);
      repeat (600) @(negedge clk_sys);
      chk({digit_request_n, code_valid}, 4'h3);
      chk(code_value, 4'h2);
      soft_flags = 4'h6;
      for (int i = 0; i < 6; i++) take(4'(i + 2), KIND_NUMERAL);
      take(4'hf, KIND_RESUME);
      chk(flag_out_n, 4'h9);
   endtask : t_stall
   task automatic t_flags;
      soft_flags = 4'h5;
      strobe(flag_instr);
      chk(flag_out_n, 4'ha);
      chk(transfer_flag_output, 1'b1);
      soft_flags = 4'h8;
      @(negedge clk_sys) inhibit = 1'b1;
      chk(flag_out_n, 4'ha);
      strobe(flag_instr);
      chk(flag_out_n, 4'hf);
      inhibit = 1'b0;
      strobe(flag_instr);
      chk({transfer_flag_output, flag_out_n[2:0]}, 4'h7);
      // Set flag 2 with flag 3 set, then clear flag 3; the outputs copy the last soft flags.
      soft_flags = 4'hc;
      strobe(flag_instr);
      soft_flags = 4'h4;
      strobe(flag_instr);
      chk({transfer_flag_output, ~flag_out_n[2:0]}, 4'hc);
   endtask : t_flags
   task automatic tally_and_finish;
      if (error_cnt == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish
   // Watchdog well beyond the thousand or so cycles the tests need.
   initial begin
      #1000000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      {srst, entry_start, code_ready, flag_instr, inhibit} = 5'h10;
      soft_flags = 4'h0;
      repeat (8) @(negedge clk_sys);
      srst = 1'b0;
      t_reset();
      t_string();
      t_stall();
      t_flags();
      tally_and_finish();
   end
endmodule : digit_entry_bench
